// File: rtl/timer8_cfg.svh
// register offsets, field positions, reset values and tick divisors
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CONTROL_A   5'h00
`define OFS_CONTROL_B   5'h04
`define OFS_COUNT       5'h08
`define OFS_COMPARE_A   5'h0C
`define OFS_COMPARE_B   5'h10
`define OFS_FLAGS       5'h14
`define OFS_IRQ_ENABLE  5'h18

// ****************************************************************
// field positions
// ****************************************************************
`define CTLA_WGM_LO     0
`define CTLA_COMB_LO    4
`define CTLA_COMA_LO    6
`define CTLB_CS_LO      0
`define CTLB_WGM2       3
`define CTLB_FORCE_B    6
`define CTLB_FORCE_A    7
`define FLG_OVERFLOW    0
`define FLG_CMP_A       1
`define FLG_CMP_B       2

// ****************************************************************
// values
// ****************************************************************
`define COUNT_BOTTOM    8'h00
`define COUNT_MAX       8'hFF
`define RESET_BYTE      8'h00
`define PRESC_WIDTH     10
`define PRESC_DIV8      10'h007
`define PRESC_DIV64     10'h03F
`define PRESC_DIV256    10'h0FF
`define PRESC_DIV1024   10'h3FF

`endif

// File: rtl/timer8_pkg.sv
// types shared by the timer core and its tick generator
package timer8_pkg;

  typedef enum logic [2:0] {
    CS_STOP   = 3'h0,
    CS_DIV1   = 3'h1,
    CS_DIV8   = 3'h2,
    CS_DIV64  = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1K  = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } clock_select_t;

  typedef enum logic [2:0] {
    WM_NORMAL    = 3'h0,
    WM_PHASE_MAX = 3'h1,
    WM_CLEAR     = 3'h2,
    WM_FAST_MAX  = 3'h3,
    WM_PHASE_A   = 3'h5,
    WM_FAST_A    = 3'h7
  } waveform_mode_t;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } count_dir_t;

endpackage

// File: rtl/tick_if.sv
// carrier between timer core and tick generator
interface tick_if;
  import timer8_pkg::*;
  clock_select_t clock_select_field;
  logic          timer_tick;
  modport core (output clock_select_field, input timer_tick);
  modport gen  (input clock_select_field, output timer_tick);
endinterface

// File: rtl/timer8_tick_gen.sv
// timer tick generator: prescaler taps and external edge select
`include "timer8_cfg.svh"
module timer8_tick_gen
  import timer8_pkg::*;
(
  input  wire logic clk_i,         // system clock
  input  wire logic rst_i,         // async reset, high
  input  wire logic ext_tick_i,    // external count source level
  tick_if.gen       tk             // select in, tick out
);
  logic [`PRESC_WIDTH-1:0] presc_q;
  logic                    ext_q;
  logic                    tick_c;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + `PRESC_WIDTH'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_tick_i;
    end
  end

  // zero select gives no tick at all
  always_comb begin
    case (tk.clock_select_field)
      CS_STOP:     tick_c = 1'b0;
      CS_DIV1:     tick_c = 1'b1;
      CS_DIV8:     tick_c = (presc_q[2:0] == `PRESC_DIV8);
      CS_DIV64:    tick_c = (presc_q[5:0] == `PRESC_DIV64);
      CS_DIV256:   tick_c = (presc_q[7:0] == `PRESC_DIV256);
      CS_DIV1K:    tick_c = (presc_q == `PRESC_DIV1024);
      CS_EXT_FALL: tick_c = ext_q & ~ext_tick_i;
      CS_EXT_RISE: tick_c = ~ext_q & ext_tick_i;
      default:     tick_c = 1'b0;
    endcase
  end

  assign tk.timer_tick = tick_c;
endmodule

// File: rtl/timer8_counter_compare_unit.sv
// 8-bit timer core: counter, two compare units, flags, pin override
//
// Operation
// - counter clears, increments or decrements per tick
// - clock select zero stops the tick
// - counter readable and writable at any time
// - software counter write beats count or clear
// - three-bit mode split over two controls
// - overflow flag set per mode, interrupt source
// - counter compared against both compare values
// - compare flag set on tick after match
// - flag interrupts; cleared by service or write-one
// - compare values buffered only in PWM modes
// - access hits buffer or active register
// - force strobe acts like match, no flag
// - counter write blocks matches next tick
// - output state survives mode changes
// - output mode unbuffered, applies next match
// - output state cleared on reset
// - nonzero output mode overrides port value
// - pin driven only when direction is output
// - output mode zero leaves state unchanged
// - top and bottom indications drive waveform
// - bottom 0x00, max 0xFF, top per mode
// - mode zero wraps, overflow at zero
// - mode two clears on compare A
// - modes three and seven single-slope PWM
`include "timer8_cfg.svh"
module timer8_counter_compare_unit
  import timer8_pkg::*;
(
  input  wire logic        clk_i,           // system clock
  input  wire logic        rst_i,           // async reset, high
  input  wire logic [4:0]  avs_address_i,   // byte address
  input  wire logic        avs_read_i,      // read request
  input  wire logic        avs_write_i,     // write request
  input  wire logic [31:0] avs_writedata_i, // write data
  input  wire logic [3:0]  avs_byteenable_i, // byte lanes
  output logic      [31:0] avs_readdata_o,  // read data
  output logic             avs_waitrequest_o, // stall
  input  wire logic        ext_tick_i,      // external count source
  input  wire logic        ovf_ack_i,       // overflow irq serviced
  input  wire logic        cmp_a_ack_i,     // compare a irq serviced
  input  wire logic        cmp_b_ack_i,     // compare b irq serviced
  output logic             ovf_irq_o,       // overflow irq request
  output logic             cmp_a_irq_o,     // compare a irq request
  output logic             cmp_b_irq_o,     // compare b irq request
  input  wire logic [1:0]  port_value_i,    // port data, {b,a}
  input  wire logic [1:0]  pin_direction_bit_i, // 1 = output, {b,a}
  output logic      [1:0]  wave_output_o,   // pin level, {b,a}
  output logic      [1:0]  wave_oe_n_o      // pin enable low, {b,a}
);
  import timer8_pkg::*;

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = m[0];
  endfunction

  function automatic logic is_phase(input logic [2:0] m);
    is_phase = m[0] & ~m[1];
  endfunction

  // next output state for a match; mode bits and up/down in
  function automatic logic match_level(input logic [1:0] com,
                                       input logic       cur,
                                       input logic       pwm,
                                       input logic       down,
                                       input logic       tgl_ok);
    match_level = cur;
    if (com == 2'h1) begin
      if (!pwm || tgl_ok) begin
        match_level = ~cur;
      end
    end else if (com == 2'h2) begin
      match_level = pwm & down;
    end else if (com == 2'h3) begin
      match_level = ~(pwm & down);
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  tick_if tk ();

  logic [1:0]  wgm_lo_q;
  logic        wgm_hi_q;
  logic [1:0]  com_a_q;
  logic [1:0]  com_b_q;
  logic [2:0]  cs_q;
  logic [7:0]  count_q;
  count_dir_t  dir_q;
  logic [7:0]  cmp_a_q;
  logic [7:0]  cmp_b_q;
  logic [7:0]  buf_a_q;
  logic [7:0]  buf_b_q;
  logic [2:0]  flags_q;
  logic [2:0]  irq_en_q;
  logic        block_q;
  logic [1:0]  oc_q;
  logic        ack_q;
  logic [31:0] rdata_q;

  logic [2:0]  wave_mode;
  logic        pwm;
  logic        phase;
  logic [7:0]  top;
  logic        at_top;
  logic        at_bottom;
  logic        tick;
  logic        acc;
  logic        wr;
  logic        wr_count;
  logic [7:0]  wbyte;
  logic [1:0]  hit;
  logic [1:0]  match_ev;
  logic        dbuf_load;
  logic        ovf_ev;
  logic [1:0]  force_ev;
  logic [2:0]  w1c;
  logic [2:0]  ack_vec;

  assign wave_mode = {wgm_hi_q, wgm_lo_q};
  assign pwm       = is_pwm(wave_mode);
  assign phase     = is_phase(wave_mode);

  // ****************************************************************
  // tick source
  // ****************************************************************
  assign tk.clock_select_field = clock_select_t'(cs_q);
  assign tick = tk.timer_tick;

  timer8_tick_gen u_tick (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ext_tick_i (ext_tick_i),
    .tk         (tk.gen)
  );

  // ****************************************************************
  // register bus: one wait state, then acknowledge
  // ****************************************************************
  assign acc   = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr    = avs_write_i & ack_q & avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];
  assign wr_count = wr && (avs_address_i == `OFS_COUNT);
  assign avs_readdata_o = rdata_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  // read data captured in the wait cycle, stands at the accept edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (acc && avs_read_i) begin
      if (avs_address_i == `OFS_CONTROL_A) begin
        rdata_q <= {24'h00_0000, com_a_q, com_b_q, 2'b00, wgm_lo_q};
      end else if (avs_address_i == `OFS_CONTROL_B) begin
        rdata_q <= {24'h00_0000, 4'h0, wgm_hi_q, cs_q};
      end else if (avs_address_i == `OFS_COUNT) begin
        rdata_q <= {24'h00_0000, count_q};
      end else if (avs_address_i == `OFS_COMPARE_A) begin
        rdata_q <= {24'h00_0000, buf_a_q};
      end else if (avs_address_i == `OFS_COMPARE_B) begin
        rdata_q <= {24'h00_0000, buf_b_q};
      end else if (avs_address_i == `OFS_FLAGS) begin
        rdata_q <= {29'h0000_0000, flags_q};
      end else if (avs_address_i == `OFS_IRQ_ENABLE) begin
        rdata_q <= {29'h0000_0000, irq_en_q};
      end else begin
        rdata_q <= '0;
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wgm_lo_q <= '0;
      com_a_q  <= '0;
      com_b_q  <= '0;
    end else if (wr && avs_address_i == `OFS_CONTROL_A) begin
      wgm_lo_q <= wbyte[`CTLA_WGM_LO +: 2];
      com_a_q  <= wbyte[`CTLA_COMA_LO +: 2];
      com_b_q  <= wbyte[`CTLA_COMB_LO +: 2];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_q     <= '0;
      wgm_hi_q <= 1'b0;
    end else if (wr && avs_address_i == `OFS_CONTROL_B) begin
      cs_q     <= wbyte[`CTLB_CS_LO +: 3];
      wgm_hi_q <= wbyte[`CTLB_WGM2];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en_q <= '0;
    end else if (wr && avs_address_i == `OFS_IRQ_ENABLE) begin
      irq_en_q <= wbyte[2:0];
    end
  end

  // force strobes read back as zero; ignored in PWM modes
  assign force_ev[0] = wr && avs_address_i == `OFS_CONTROL_B
                       && wbyte[`CTLB_FORCE_A] && !pwm;
  assign force_ev[1] = wr && avs_address_i == `OFS_CONTROL_B
                       && wbyte[`CTLB_FORCE_B] && !pwm;

  // ****************************************************************
  // counter
  // ****************************************************************
  assign top = (wave_mode == WM_CLEAR || wave_mode == WM_FAST_A
                || wave_mode == WM_PHASE_A) ? cmp_a_q
                                            : `COUNT_MAX;
  assign at_top    = (count_q == top);
  assign at_bottom = (count_q == `COUNT_BOTTOM);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= `RESET_BYTE;
      dir_q   <= DIR_UP;
    end else if (wr_count) begin
      count_q <= wbyte;
    end else if (tick) begin
      if (phase) begin
        if (dir_q == DIR_UP) begin
          if (at_top) begin
            dir_q   <= DIR_DOWN;
            count_q <= count_q - 8'h01;
          end else begin
            count_q <= count_q + 8'h01;
          end
        end else begin
          if (at_bottom) begin
            dir_q   <= DIR_UP;
            count_q <= count_q + 8'h01;
          end else begin
            count_q <= count_q - 8'h01;
          end
        end
      end else if (wave_mode != WM_NORMAL && at_top) begin
        count_q <= `COUNT_BOTTOM;
        dir_q   <= DIR_UP;
      end else begin
        count_q <= count_q + 8'h01;
        dir_q   <= DIR_UP;
      end
    end
  end

  // ****************************************************************
  // compare values, double buffered in PWM modes
  // ****************************************************************
  assign dbuf_load = tick && (phase ? (at_top && dir_q == DIR_UP)
                                    : at_top);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_a_q <= `RESET_BYTE;
      buf_b_q <= `RESET_BYTE;
    end else begin
      if (wr && avs_address_i == `OFS_COMPARE_A) begin
        buf_a_q <= wbyte;
      end
      if (wr && avs_address_i == `OFS_COMPARE_B) begin
        buf_b_q <= wbyte;
      end
    end
  end

  // without buffering the active value tracks every write at once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_a_q <= `RESET_BYTE;
      cmp_b_q <= `RESET_BYTE;
    end else if (!pwm) begin
      cmp_a_q <= (wr && avs_address_i == `OFS_COMPARE_A)
                 ? wbyte : buf_a_q;
      cmp_b_q <= (wr && avs_address_i == `OFS_COMPARE_B)
                 ? wbyte : buf_b_q;
    end else if (dbuf_load) begin
      cmp_a_q <= buf_a_q;
      cmp_b_q <= buf_b_q;
    end
  end

  // ****************************************************************
  // match, blocking and flags
  // ****************************************************************
  assign hit = {count_q == cmp_b_q, count_q == cmp_a_q};

  // a count write stays armed until a tick consumes it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  assign match_ev = (tick && !block_q) ? hit : 2'b00;

  always_comb begin
    if (phase) begin
      ovf_ev = tick && at_bottom && dir_q == DIR_DOWN;
    end else if (pwm) begin
      ovf_ev = tick && at_top;
    end else begin
      ovf_ev = tick && count_q == `COUNT_MAX;
    end
  end

  assign w1c = (wr && avs_address_i == `OFS_FLAGS) ? wbyte[2:0] : 3'b000;
  assign ack_vec = {cmp_b_ack_i, cmp_a_ack_i, ovf_ack_i};

  // a set in the clearing cycle wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~(w1c | ack_vec))
                 | {match_ev[1], match_ev[0], ovf_ev};
    end
  end

  assign ovf_irq_o   = flags_q[`FLG_OVERFLOW] & irq_en_q[`FLG_OVERFLOW];
  assign cmp_a_irq_o = flags_q[`FLG_CMP_A] & irq_en_q[`FLG_CMP_A];
  assign cmp_b_irq_o = flags_q[`FLG_CMP_B] & irq_en_q[`FLG_CMP_B];

  // ****************************************************************
  // waveform state; untouched by mode changes
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_q <= 2'b00;
    end else begin
      if (force_ev[0]) begin
        oc_q[0] <= match_level(com_a_q, oc_q[0], 1'b0, 1'b0, 1'b0);
      end else if (match_ev[0]) begin
        oc_q[0] <= match_level(com_a_q, oc_q[0], pwm,
                               dir_q == DIR_DOWN, wgm_hi_q);
      end else if (pwm && !phase && tick && at_top && com_a_q[1]) begin
        oc_q[0] <= ~com_a_q[0];
      end
      if (force_ev[1]) begin
        oc_q[1] <= match_level(com_b_q, oc_q[1], 1'b0, 1'b0, 1'b0);
      end else if (match_ev[1]) begin
        oc_q[1] <= match_level(com_b_q, oc_q[1], pwm,
                               dir_q == DIR_DOWN, 1'b0);
      end else if (pwm && !phase && tick && at_top && com_b_q[1]) begin
        oc_q[1] <= ~com_b_q[0];
      end
    end
  end

  // ****************************************************************
  // pin override
  // ****************************************************************
  assign wave_output_o[0] = (com_a_q != 2'b00) ? oc_q[0]
                                               : port_value_i[0];
  assign wave_output_o[1] = (com_b_q != 2'b00) ? oc_q[1]
                                               : port_value_i[1];
  assign wave_oe_n_o = ~pin_direction_bit_i;

endmodule

// File: testbench/timer8_counter_compare_unit_checker.sv
// port-level assertions for the timer core
`include "timer8_cfg.svh"
module timer8_ccu_checker (
  input wire logic        clk_i,               // system clock
  input wire logic        rst_i,               // async reset
  input wire logic [4:0]  avs_address_i,       // byte address
  input wire logic        avs_read_i,          // read
  input wire logic        avs_write_i,         // write
  input wire logic [31:0] avs_writedata_i,     // write data
  input wire logic [3:0]  avs_byteenable_i,    // lanes
  input wire logic [31:0] avs_readdata_o,      // read data
  input wire logic        avs_waitrequest_o,   // stall
  input wire logic        ovf_ack_i,           // ovf serviced
  input wire logic        cmp_b_ack_i,         // cmp b serviced
  input wire logic        ovf_irq_o,           // ovf request
  input wire logic        cmp_a_irq_o,         // cmp a request
  input wire logic        cmp_b_irq_o,         // cmp b request
  input wire logic [1:0]  port_value_i,        // port data
  input wire logic [1:0]  pin_direction_bit_i, // direction
  input wire logic [1:0]  wave_output_o,       // pin level
  input wire logic [1:0]  wave_oe_n_o          // enable, low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cs_q;
  logic [1:0] com_a_q, stop_q;
  logic       wr_done, wr_ctl, idle;
  assign wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign wr_ctl  = wr_done && avs_address_i == `OFS_CONTROL_B;
  // idle starts two cycles after the select reaches zero
  assign idle    = (cs_q == 3'h0) && (stop_q == 2'h2);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_q    <= 3'h0;
      com_a_q <= 2'h0;
    end else if (wr_done && avs_address_i == `OFS_CONTROL_A) begin
      com_a_q <= avs_writedata_i[7:6];
    end else if (wr_ctl) begin
      cs_q <= avs_writedata_i[2:0];
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_q <= 2'h0;
    end else if (cs_q != 3'h0) begin
      stop_q <= 2'h0;
    end else if (stop_q != 2'h2) begin
      stop_q <= stop_q + 2'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_req_wait;
    $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_req_wait: assert property (p_req_wait)
    else $error("one wait state missed");
  property p_rd_width;
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000;
  endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("readdata high bits");
  property p_oe;
    wave_oe_n_o == ~pin_direction_bit_i;
  endproperty
  a_oe: assert property (p_oe)
    else $error("oe wrong");
  property p_pass;
    com_a_q == 2'h0 |-> wave_output_o[0] == port_value_i[0];
  endproperty
  a_pass: assert property (p_pass)
    else $error("port not passed");
  property p_hold;
    idle && com_a_q != 2'h0 && !avs_write_i |=> $stable(wave_output_o[0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output moved while stopped");
  property p_stop_flags;
    idle && !avs_write_i && !ovf_ack_i && !cmp_b_ack_i
      |=> $stable({ovf_irq_o, cmp_a_irq_o, cmp_b_irq_o});
  endproperty
  a_stop_flags: assert property (p_stop_flags)
    else $error("flag changed while stopped");
  property p_ack;
    ovf_ack_i && idle |=> !ovf_irq_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ovf not cleared");
  property p_w1c;
    wr_done && avs_address_i == `OFS_FLAGS && avs_writedata_i[2] && idle
      |=> !cmp_b_irq_o;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("cmp b not cleared");
  property p_force;
    wr_ctl && avs_writedata_i[7] && idle |=> $stable(cmp_a_irq_o) [*3];
  endproperty
  a_force: assert property (p_force)
    else $error("force set flag");
  c_force: cover property (wr_ctl && avs_writedata_i[7]);
  c_ack: cover property (ovf_ack_i && idle);
  c_cmp: cover property ($rose(cmp_b_irq_o));
endmodule

bind timer8_counter_compare_unit timer8_ccu_checker u_chk (.*);

// File: testbench/port_pin_model.sv
// port data, direction and pad level beside the timer outputs
module port_pin_model (
  input  wire logic       clk_i,               // system clock
  input  wire logic       rst_i,               // async reset
  input  wire logic [1:0] port_set_i,          // software port data
  input  wire logic [1:0] dir_set_i,           // software direction
  input  wire logic [1:0] wave_output_i,       // timer pin level
  input  wire logic [1:0] wave_oe_n_i,         // timer enable, low
  output logic      [1:0] port_value_o,        // port register
  output logic      [1:0] pin_direction_bit_o, // direction register
  output logic      [1:0] pin_o                // pad level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] last_q;
  // direction set in the same cycle as the port data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_value_o        <= 2'h0;
      pin_direction_bit_o <= 2'h0;
    end else begin
      port_value_o        <= port_set_i;
      pin_direction_bit_o <= dir_set_i;
    end
  end
  always_ff @(posedge clk_i) begin
    last_q <= pin_o;
  end
  // no pull: undriven pad shows the inverse
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_o[i] = wave_oe_n_i[i] ? ~last_q[i] : wave_output_i[i];
    end
  end
endmodule

// File: testbench/timer8_counter_compare_unit_tb.sv
// self-checking bench for the timer core
`include "timer8_cfg.svh"
module timer8_counter_compare_unit_tb;
  import timer8_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        ext_tick_i, ovf_ack_i, cmp_a_ack_i, cmp_b_ack_i;
  logic        ovf_irq_o, cmp_a_irq_o, cmp_b_irq_o;
  logic [4:0]  avs_address_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [1:0]  port_value_i, pin_direction_bit_i, wave_output_o;
  logic [1:0]  wave_oe_n_o, port_set, dir_set, pin;
  int          error_cnt;
  int          tests_run;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } row_t;
  row_t rows [7] = '{
    '{`OFS_COUNT, 8'hA5, 8'hA5}, '{`OFS_COMPARE_A, 8'h3C, 8'h3C},
    '{`OFS_COMPARE_B, 8'h81, 8'h81}, '{`OFS_CONTROL_B, 8'hC0, 8'h00},
    '{5'h1C, 8'hFF, 8'h00}, '{`OFS_FLAGS, 8'h07, 8'h00},
    '{`OFS_IRQ_ENABLE, 8'h07, 8'h07}};

  timer8_counter_compare_unit DUT (.*);
  port_pin_model partner (
    .clk_i, .rst_i, .port_set_i(port_set), .dir_set_i(dir_set),
    .wave_output_i(wave_output_o), .wave_oe_n_i(wave_oe_n_o),
    .port_value_o(port_value_i), .pin_direction_bit_o(pin_direction_bit_i),
    .pin_o(pin));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // settled values read mid-cycle; request stands to the accept edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] r);
    logic s;
    {avs_address_i, avs_writedata_i} <= {a, 24'h00_0000, d};
    avs_byteenable_i <= be;
    {avs_write_i, avs_read_i} <= {w, !w};
    do begin
      @(negedge clk_i);
      s = avs_waitrequest_o;
      r = avs_readdata_o;
      @(posedge clk_i);
    end while (s !== 1'b0);
    {avs_write_i, avs_read_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00, 4'h1, q);
    chk(n, e, q[7:0]);
  endtask
  // one rising edge of the external source per count
  task automatic tick(input int n);
    repeat (2 * n) begin
      ext_tick_i <= !ext_tick_i;
      repeat (4) @(posedge clk_i);
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    end_sim();
  end
  initial begin
    rst_i = 1'b1;
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
    avs_byteenable_i = 4'h0;
    {ext_tick_i, ovf_ack_i, cmp_a_ack_i, cmp_b_ack_i} = 4'h0;
    {port_set, dir_set} = 4'hC;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(`OFS_COUNT, 8'h00, "count_reset");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdc(rows[i].addr, rows[i].rexp, "table_row");
    end
    bus(1'b1, `OFS_COUNT, 8'h11, 4'h0, q);
    rdc(`OFS_COUNT, 8'hA5, "lane_off");
    for (int m = 0; m < 8; m++) begin
      wr(`OFS_CONTROL_A, {6'h00, m[1:0]});
      wr(`OFS_CONTROL_B, {4'h0, m[2], 3'h0});
      rdc(`OFS_CONTROL_A, {6'h00, m[1:0]}, "mode_low");
      rdc(`OFS_CONTROL_B, {4'h0, m[2], 3'h0}, "mode_high");
    end
    wr(`OFS_CONTROL_A, 8'h00);
    wr(`OFS_CONTROL_B, 8'h00);
    wr(`OFS_CONTROL_A, 8'h40);
    chk("oc_after_reset", 8'h00, 8'(wave_output_o[0]));
    chk("oe_input", 8'h03, 8'(wave_oe_n_o));
    wr(`OFS_CONTROL_B, 8'h80);
    chk("forced_toggle", 8'h01, 8'(wave_output_o[0]));
    rdc(`OFS_FLAGS, 8'h00, "force_no_flag");
    dir_set <= 2'b01;
    repeat (2) @(posedge clk_i);
    chk("pin_driven", 8'h01, 8'(pin[0]));
    wr(`OFS_CONTROL_A, 8'h43);
    wr(`OFS_CONTROL_A, 8'h40);
    chk("oc_kept", 8'h01, 8'(wave_output_o[0]));
    port_set <= 2'b10;
    wr(`OFS_CONTROL_A, 8'h00);
    chk("port_pass", 8'h00, 8'(wave_output_o[0]));
    wr(`OFS_CONTROL_B, 8'h80);
    wr(`OFS_CONTROL_A, 8'h40);
    chk("mode_zero_idle", 8'h01, 8'(wave_output_o[0]));
    wr(`OFS_CONTROL_B, 8'h80);
    chk("new_mode_used", 8'h00, 8'(wave_output_o[0]));
    wr(`OFS_COUNT, 8'hFE);
    tick(1);
    rdc(`OFS_COUNT, 8'hFE, "stopped");
    wr(`OFS_CONTROL_B, 8'h07);
    tick(1);
    rdc(`OFS_COUNT, 8'hFF, "count_up");
    chk("no_ovf_yet", 8'h00, 8'(ovf_irq_o));
    tick(1);
    rdc(`OFS_COUNT, 8'h00, "wrap");
    chk("ovf_irq", 8'h01, 8'(ovf_irq_o));
    wr(`OFS_COMPARE_B, 8'h03);
    tick(3);
    chk("flag_late", 8'h00, 8'(cmp_b_irq_o));
    tick(1);
    chk("flag_set", 8'h01, 8'(cmp_b_irq_o));
    wr(`OFS_CONTROL_B, 8'h00);
    ovf_ack_i <= 1'b1;
    @(posedge clk_i);
    ovf_ack_i <= 1'b0;
    @(posedge clk_i);
    wr(`OFS_FLAGS, 8'h04);
    chk("irqs_cleared", 8'h00, 8'({ovf_irq_o, cmp_b_irq_o}));
    wr(`OFS_COUNT, 8'h03);
    wr(`OFS_CONTROL_B, 8'h07);
    tick(1);
    rdc(`OFS_COUNT, 8'h04, "after_block");
    chk("match_blocked", 8'h00, 8'(cmp_b_irq_o));
    wr(`OFS_CONTROL_A, 8'h02);
    wr(`OFS_COMPARE_A, 8'h05);
    wr(`OFS_COUNT, 8'h04);
    tick(2);
    rdc(`OFS_COUNT, 8'h00, "clear_on_match");
    chk("flag_a", 8'h01, 8'(cmp_a_irq_o));
    wr(`OFS_CONTROL_A, 8'h03);
    wr(`OFS_CONTROL_B, 8'h0F);
    wr(`OFS_COMPARE_A, 8'h02);
    rdc(`OFS_COMPARE_A, 8'h02, "buffer_read");
    tick(3);
    rdc(`OFS_COUNT, 8'h03, "old_top_kept");
    tick(3);
    rdc(`OFS_COUNT, 8'h00, "top_a_wrap");
    tick(3);
    rdc(`OFS_COUNT, 8'h00, "top_reloaded");
    wr(`OFS_CONTROL_B, 8'h07);
    wr(`OFS_COUNT, 8'hFE);
    tick(2);
    rdc(`OFS_COUNT, 8'h00, "top_max_wrap");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(`OFS_COUNT, 8'h00, "count_mid_reset");
    end_sim();
  end
endmodule
